// >>> hdl/dshcp_pkg.sv
// Constants and types shared by the dual serial host control port.
package dshcp_pkg;

  // ***********************************************************************
  // Strap levels and address
  // ***********************************************************************
  localparam logic       C_STRAP_SPI    = 1'b0;
  localparam logic       C_STRAP_I2C    = 1'b1;
  localparam logic [4:0] C_ADDR_UPPER   = 5'h19;
  localparam logic       C_RW_READ      = 1'b1;

  // ***********************************************************************
  // Counts and reset values
  // ***********************************************************************
  localparam logic [3:0] C_BITS_PER_BYTE = 4'h8;
  localparam logic [2:0] C_STATUS_BYTES  = 3'h4;
  localparam logic [6:0] C_ADDR_RESET    = 7'h00;
  localparam logic [7:0] C_BYTE_RESET    = 8'h00;

  // ***********************************************************************
  // I2C engine states
  // ***********************************************************************
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_AACK = 7'h04,
    ST_WR   = 7'h08,
    ST_WACK = 7'h10,
    ST_RD   = 7'h20,
    ST_RACK = 7'h40
  } dshcp_state_t;

endpackage

// >>> hdl/dshcp_strap.sv
// Strap capture for protocol select and low address bits.
`timescale 1ns/1ps
module dshcp_strap
  import dshcp_pkg::*;
(
  // Clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_sys_rst,
  // Strap levels
  input  wire logic       i_mode_strap,
  input  wire logic       i_bit1_strap,
  input  wire logic       i_bit0_strap,
  // Captured values
  output logic            o_valid,
  output logic            o_i2c_mode,
  output logic [6:0]      o_addr
);

  logic       ok_q, ok_d;
  logic       mode_q, mode_d;
  logic [1:0] low_q, low_d;

  // Captured on the first edge after release, then frozen until reset.
  always_comb begin
    ok_d   = ok_q;
    mode_d = mode_q;
    low_d  = low_q;
    if (!ok_q) begin
      ok_d   = 1'b1;
      mode_d = (i_mode_strap == C_STRAP_I2C);
      low_d  = {i_bit1_strap, i_bit0_strap};
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ok_q   <= 1'b0;
      mode_q <= 1'b0;
      low_q  <= 2'h0;
    end else begin
      ok_q   <= ok_d;
      mode_q <= mode_d;
      low_q  <= low_d;
    end
  end

  assign o_valid    = ok_q;
  assign o_i2c_mode = mode_q;
  assign o_addr     = {C_ADDR_UPPER, low_q};

endmodule // dshcp_strap

// >>> hdl/dshcp_spi_slave.sv
// SPI slave engine for clock modes 0 and 3.
`timescale 1ns/1ps
module dshcp_spi_slave
  import dshcp_pkg::*;
(
  // Clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_sys_rst,
  // Link pins
  input  wire logic       i_en,
  input  wire logic       i_sclk,
  input  wire logic       i_mosi,
  input  wire logic       i_cs_n,
  output logic            o_miso,
  output logic            o_miso_oe,
  // Byte side
  input  wire logic [7:0] i_tx_byte,
  output logic            o_tx_take,
  output logic            o_start,
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_byte
);

  logic       sclk_q, csn_q, oe_q, oe_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] shi_q, shi_d, sho_q, sho_d;
  logic       sel, rise, fall;

  assign sel  = i_en & ~i_cs_n;
  assign rise = i_sclk & ~sclk_q;
  assign fall = ~i_sclk & sclk_q;

  // Sample on rising edges, shift out on falling edges. In mode 3 the
  // first falling edge comes before any rising edge and is skipped.
  always_comb begin
    cnt_d      = cnt_q;
    shi_d      = shi_q;
    sho_d      = sho_q;
    oe_d       = oe_q;
    o_tx_take  = 1'b0;
    o_start    = 1'b0;
    o_rx_valid = 1'b0;
    o_rx_byte  = {shi_q[6:0], i_mosi};
    if (!sel) begin
      oe_d  = 1'b0;
      cnt_d = 4'h0;
    end else if (csn_q) begin
      sho_d     = i_tx_byte;
      o_tx_take = 1'b1;
      o_start   = 1'b1;
      oe_d      = 1'b1;
      cnt_d     = 4'h0;
    end else if (rise) begin
      shi_d = {shi_q[6:0], i_mosi};
      cnt_d = cnt_q + 4'h1;
      if (cnt_q == C_BITS_PER_BYTE - 4'h1) begin
        o_rx_valid = 1'b1;
      end
    end else if (fall && cnt_q != 4'h0) begin
      if (cnt_q == C_BITS_PER_BYTE) begin
        sho_d     = i_tx_byte;
        o_tx_take = 1'b1;
        cnt_d     = 4'h0;
      end else begin
        sho_d = {sho_q[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sclk_q <= 1'b0;
      csn_q  <= 1'b1;
      oe_q   <= 1'b0;
      cnt_q  <= 4'h0;
      shi_q  <= C_BYTE_RESET;
      sho_q  <= C_BYTE_RESET;
    end else begin
      sclk_q <= i_sclk;
      csn_q  <= i_cs_n | ~i_en;
      oe_q   <= oe_d;
      cnt_q  <= cnt_d;
      shi_q  <= shi_d;
      sho_q  <= sho_d;
    end
  end

  assign o_miso    = sho_q[7];
  assign o_miso_oe = oe_q;

endmodule // dshcp_spi_slave

// >>> hdl/dshcp_top.sv
// Host control port: SPI or I2C slave chosen by strap.
`timescale 1ns/1ps
module dshcp_top
  import dshcp_pkg::*;
(
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_sys_rst,
  // Strap and link pins
  input  wire logic        i_interface_select_strap,
  input  wire logic        i_sclk,
  input  wire logic        i_chip_select_n,
  input  wire logic        i_mosi,
  output logic             o_mosi,
  output logic             o_mosi_oe,
  input  wire logic        i_miso,
  output logic             o_miso,
  output logic             o_miso_oe,
  // Response source
  input  wire logic [31:0] i_status,
  input  wire logic [7:0]  i_rsp_data,
  output logic             o_rsp_take,
  // Command sink and state
  output logic [7:0]       o_cmd_data,
  output logic             o_cmd_valid,
  output logic             o_cmd_first,
  output logic             o_busy,
  output logic             o_i2c_mode,
  output logic [6:0]       o_dev_addr
);

  // ***********************************************************************
  // Straps
  // ***********************************************************************
  logic       strap_ok, i2c_mode;
  logic [6:0] dev_addr;

  dshcp_strap u_strap (
    .i_sys_clk    (i_sys_clk),
    .i_sys_rst    (i_sys_rst),
    .i_mode_strap (i_interface_select_strap),
    .i_bit1_strap (i_chip_select_n),
    .i_bit0_strap (i_miso),
    .o_valid      (strap_ok),
    .o_i2c_mode   (i2c_mode),
    .o_addr       (dev_addr)
  );

  // ***********************************************************************
  // Response byte selection
  // ***********************************************************************
  logic [2:0] rsp_cnt_q, rsp_cnt_d, rsp_idx;
  logic [7:0] tx_byte;
  logic       take;

  // Status goes out most significant byte first, so CTS leads.
  always_comb begin
    unique case (rsp_idx)
      3'h0:    tx_byte = i_status[31:24];
      3'h1:    tx_byte = i_status[23:16];
      3'h2:    tx_byte = i_status[15:8];
      3'h3:    tx_byte = i_status[7:0];
      default: tx_byte = i_rsp_data;
    endcase
  end

  // ***********************************************************************
  // SPI engine
  // ***********************************************************************
  logic       spi_en, spi_miso, spi_oe, spi_take, spi_start, spi_rx_v;
  logic [7:0] spi_rx;

  assign spi_en = strap_ok & ~i2c_mode;

  dshcp_spi_slave u_spi (
    .i_sys_clk  (i_sys_clk),
    .i_sys_rst  (i_sys_rst),
    .i_en       (spi_en),
    .i_sclk     (i_sclk),
    .i_mosi     (i_mosi),
    .i_cs_n     (i_chip_select_n),
    .o_miso     (spi_miso),
    .o_miso_oe  (spi_oe),
    .i_tx_byte  (tx_byte),
    .o_tx_take  (spi_take),
    .o_start    (spi_start),
    .o_rx_valid (spi_rx_v),
    .o_rx_byte  (spi_rx)
  );

  // ***********************************************************************
  // I2C engine
  // ***********************************************************************
  dshcp_state_t st_q, st_d;
  logic         scl_q, sda_q, oe_q, oe_d, rw_q, rw_d, ackd_q, ackd_d;
  logic [3:0]   cnt_q, cnt_d;
  logic [7:0]   sh_q, sh_d;
  logic         rise, fall, start, stop, i2c_on, i2c_rx_v, i2c_take;

  // SCL rides the SPI clock pin and SDA the MOSI pin.
  assign i2c_on = strap_ok & i2c_mode;
  assign rise   = i_sclk & ~scl_q;
  assign fall   = ~i_sclk & scl_q;
  assign start  = scl_q & i_sclk & sda_q & ~i_mosi;
  assign stop   = scl_q & i_sclk & ~sda_q & i_mosi;

  always_comb begin
    st_d     = st_q;
    cnt_d    = cnt_q;
    sh_d     = sh_q;
    oe_d     = oe_q;
    rw_d     = rw_q;
    ackd_d   = ackd_q;
    i2c_rx_v = 1'b0;
    i2c_take = 1'b0;
    if (!i2c_on || stop) begin
      st_d = ST_IDLE;
      oe_d = 1'b0;
    end else if (start) begin
      st_d  = ST_ADDR;
      cnt_d = 4'h0;
      oe_d  = 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          oe_d = 1'b0;
        end
        ST_ADDR: begin
          if (rise) begin
            sh_d  = {sh_q[6:0], i_mosi};
            cnt_d = cnt_q + 4'h1;
          end else if (fall && cnt_q == C_BITS_PER_BYTE) begin
            if (sh_q[7:1] == dev_addr) begin
              st_d = ST_AACK;
              oe_d = 1'b1;
              rw_d = sh_q[0];
            end else begin
              st_d = ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          if (fall) begin
            cnt_d = 4'h0;
            if (rw_q == C_RW_READ) begin
              st_d     = ST_RD;
              sh_d     = tx_byte;
              i2c_take = 1'b1;
              oe_d     = ~tx_byte[7];
            end else begin
              st_d = ST_WR;
              oe_d = 1'b0;
            end
          end
        end
        ST_WR: begin
          if (rise) begin
            sh_d  = {sh_q[6:0], i_mosi};
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == C_BITS_PER_BYTE - 4'h1) begin
              i2c_rx_v = 1'b1;
            end
          end else if (fall && cnt_q == C_BITS_PER_BYTE) begin
            st_d = ST_WACK;
            oe_d = 1'b1;
          end
        end
        ST_WACK: begin
          if (fall) begin
            st_d  = ST_WR;
            oe_d  = 1'b0;
            cnt_d = 4'h0;
          end
        end
        ST_RD: begin
          if (rise) begin
            cnt_d = cnt_q + 4'h1;
          end else if (fall) begin
            if (cnt_q == C_BITS_PER_BYTE) begin
              st_d = ST_RACK;
              oe_d = 1'b0;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              oe_d = ~sh_q[6];
            end
          end
        end
        ST_RACK: begin
          if (rise) begin
            ackd_d = ~i_mosi;
          end else if (fall) begin
            cnt_d = 4'h0;
            if (ackd_q) begin
              st_d     = ST_RD;
              sh_d     = tx_byte;
              i2c_take = 1'b1;
              oe_d     = ~tx_byte[7];
            end else begin
              st_d = ST_IDLE;
            end
          end
        end
        default: begin
          st_d = ST_IDLE;
          oe_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_q   <= ST_IDLE;
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
      oe_q   <= 1'b0;
      rw_q   <= 1'b0;
      ackd_q <= 1'b0;
      cnt_q  <= 4'h0;
      sh_q   <= C_BYTE_RESET;
    end else begin
      st_q   <= st_d;
      scl_q  <= i_sclk;
      sda_q  <= i_mosi;
      oe_q   <= oe_d;
      rw_q   <= rw_d;
      ackd_q <= ackd_d;
      cnt_q  <= cnt_d;
      sh_q   <= sh_d;
    end
  end

  // ***********************************************************************
  // Command stream and output registers
  // ***********************************************************************
  logic       first_q, first_d, frame;
  logic       cmd_v_d, busy_d;
  logic [7:0] cmd_d;

  assign frame = spi_start | (i2c_on & start);
  assign take  = spi_take | i2c_take;
  // An SPI frame loads its first byte in the cycle that opens it, before
  // the counter has been cleared, so the frame pulse forces index zero.
  assign rsp_idx = frame ? 3'h0 : rsp_cnt_q;

  always_comb begin
    cmd_v_d   = spi_rx_v | i2c_rx_v;
    cmd_d     = i2c_on ? {sh_q[6:0], i_mosi} : spi_rx;
    first_d   = first_q;
    rsp_cnt_d = rsp_cnt_q;
    if (frame) begin
      first_d   = 1'b1;
      rsp_cnt_d = 3'h0;
    end else if (cmd_v_d) begin
      first_d = 1'b0;
    end
    if (take && rsp_idx < C_STATUS_BYTES + 3'h1) begin
      rsp_cnt_d = rsp_idx + 3'h1;
    end
    busy_d = i2c_on ? (st_d != ST_IDLE) : (spi_en & ~i_chip_select_n);
  end

  // Take pulses for status bytes stay internal; the user only sees its
  // own data bytes being consumed.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      first_q     <= 1'b0;
      rsp_cnt_q   <= 3'h0;
      o_cmd_data  <= C_BYTE_RESET;
      o_cmd_valid <= 1'b0;
      o_cmd_first <= 1'b0;
      o_rsp_take  <= 1'b0;
      o_busy      <= 1'b0;
      o_mosi      <= 1'b0;
      o_miso      <= 1'b0;
      o_miso_oe   <= 1'b0;
      o_i2c_mode  <= 1'b0;
      o_dev_addr  <= C_ADDR_RESET;
    end else begin
      first_q     <= first_d;
      rsp_cnt_q   <= rsp_cnt_d;
      o_cmd_data  <= cmd_v_d ? cmd_d : o_cmd_data;
      o_cmd_valid <= cmd_v_d;
      o_cmd_first <= cmd_v_d & first_q;
      o_rsp_take  <= take & (rsp_idx >= C_STATUS_BYTES);
      o_busy      <= busy_d;
      o_mosi      <= 1'b0;
      o_miso      <= spi_miso;
      o_miso_oe   <= spi_oe;
      o_i2c_mode  <= i2c_mode;
      o_dev_addr  <= dev_addr;
    end
  end

  assign o_mosi_oe = oe_q;

  // ***********************************************************************
  // Assertions
  // ***********************************************************************
  property p_spi_no_sda;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (strap_ok && !i2c_mode) |-> !o_mosi_oe;
  endproperty
  a_spi_no_sda: assert property (p_spi_no_sda)
    else $error("SDA driven in SPI mode");

  property p_i2c_no_miso;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      i2c_mode ##1 i2c_mode |-> !o_miso_oe;
  endproperty
  a_i2c_no_miso: assert property (p_i2c_no_miso)
    else $error("MISO strap pin driven in I2C mode");

  property p_miso_follows_cs;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (spi_en && $rose(i_chip_select_n)) |-> ##2 !o_miso_oe;
  endproperty
  a_miso_follows_cs: assert property (p_miso_follows_cs)
    else $error("MISO still driven after deselect");

  property p_addr_compose;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      $rose(strap_ok) |-> dev_addr ==
        {C_ADDR_UPPER, $past(i_chip_select_n), $past(i_miso)};
  endproperty
  a_addr_compose: assert property (p_addr_compose)
    else $error("Device address not built from straps");

  property p_strap_hold;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      strap_ok |=> $stable(dev_addr) && $stable(i2c_mode);
  endproperty
  a_strap_hold: assert property (p_strap_hold)
    else $error("Strap values changed after capture");

  property p_ack_match;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (st_q == ST_ADDR && st_d == ST_AACK) |-> sh_q[7:1] == dev_addr;
  endproperty
  a_ack_match: assert property (p_ack_match)
    else $error("Acknowledged a foreign address");

  property p_ack_len;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (st_q == ST_WACK && i2c_on && fall) |=> !o_mosi_oe;
  endproperty
  a_ack_len: assert property (p_ack_len)
    else $error("Write acknowledge held past one clock");

  property p_sda_change_low;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (i2c_on && $changed(o_mosi_oe)) |-> !$past(i_sclk);
  endproperty
  a_sda_change_low: assert property (p_sda_change_low)
    else $error("SDA drive changed while SCL high");

  property p_first_once;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      o_cmd_first |-> o_cmd_valid ##1 !o_cmd_first;
  endproperty
  a_first_once: assert property (p_first_once)
    else $error("Command flag on a non-leading byte");

  c_i2c_write: cover property (@(posedge i_sys_clk)
    st_q == ST_WACK && fall);
  c_i2c_read:  cover property (@(posedge i_sys_clk)
    st_q == ST_RACK && fall && ackd_q);
  c_spi_cmd:   cover property (@(posedge i_sys_clk)
    o_cmd_valid && o_cmd_first && !o_i2c_mode);
  c_user_rsp:  cover property (@(posedge i_sys_clk) o_rsp_take);

endmodule // dshcp_top

// >>> tb/dshcp_host_model.sv
// Host controller model: SPI master in modes 0 and 3, and I2C master.
`timescale 1ns/1ps
module dshcp_host_model (
  // Clock
  input  wire logic i_sys_clk,
  // Wire levels seen by the host
  input  wire logic i_miso_wire,
  input  wire logic i_sda_wire,
  // Host drives
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_mosi
);
  localparam int C_SPI_HALF = 4;
  // A half period of 130 cycles keeps the I2C clock below 400 kHz.
  localparam int C_I2C_HALF = 130;

  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b1;
  end

  task automatic wait_n(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask

  // ***********************************************************************
  // SPI master
  // ***********************************************************************
  task automatic spi_frame(input logic mode3, input logic [39:0] tx,
                           output logic [39:0] rx);
    o_sclk <= mode3;
    wait_n(C_SPI_HALF);
    o_cs_n <= 1'b0;
    wait_n(C_SPI_HALF);
    for (int i = 39; i >= 0; i--) begin
      if (mode3) o_sclk <= 1'b0;
      o_mosi <= tx[i];
      wait_n(C_SPI_HALF);
      o_sclk <= 1'b1;
      rx[i] = i_miso_wire;
      wait_n(C_SPI_HALF);
      if (!mode3) o_sclk <= 1'b0;
    end
    wait_n(C_SPI_HALF);
    o_cs_n <= 1'b1;
    // The data line is not left showing the last bit once released.
    o_mosi <= ~o_mosi;
    wait_n(C_SPI_HALF);
  endtask

  // ***********************************************************************
  // I2C master
  // ***********************************************************************
  task automatic i2c_bit(input logic b, output logic r);
    // Data moves a few cycles after the clock fall, never with it.
    wait_n(4);
    o_mosi <= b;
    wait_n(C_I2C_HALF);
    o_sclk <= 1'b1;
    wait_n(C_I2C_HALF);
    r = i_sda_wire;
    o_sclk <= 1'b0;
  endtask

  task automatic i2c_byte(input logic [7:0] tx, input logic ack_in,
                          output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) i2c_bit(tx[i], rx[i]);
    i2c_bit(ack_in, ack);
  endtask

  task automatic i2c_start;
    o_mosi <= 1'b1;
    wait_n(4);
    o_sclk <= 1'b1;
    wait_n(C_I2C_HALF);
    o_mosi <= 1'b0;
    wait_n(C_I2C_HALF);
    o_sclk <= 1'b0;
  endtask

  task automatic i2c_stop;
    wait_n(4);
    o_mosi <= 1'b0;
    wait_n(C_I2C_HALF);
    o_sclk <= 1'b1;
    wait_n(C_I2C_HALF);
    o_mosi <= 1'b1;
    wait_n(C_I2C_HALF);
  endtask
endmodule  // dshcp_host_model

// >>> tb/tb.sv
// Self-checking bench for the dual serial host control port.
`timescale 1ns/1ps
module tb
  import dshcp_pkg::*;
;
  logic        i_sys_clk;
  logic        i_sys_rst;
  logic        i2c_sel;
  logic        strap1;
  logic        strap0;
  logic        miso_last;
  logic [31:0] i_status;
  logic [7:0]  i_rsp_data;
  logic        host_sclk;
  logic        host_cs_n;
  logic        host_mosi;
  logic        o_mosi;
  logic        o_mosi_oe;
  logic        o_miso;
  logic        o_miso_oe;
  logic        o_rsp_take;
  logic [7:0]  o_cmd_data;
  logic        o_cmd_valid;
  logic        o_cmd_first;
  logic        o_busy;
  logic        o_i2c_mode;
  logic [6:0]  o_dev_addr;
  logic [8:0]  cmd_q[$];
  int          failures;
  int          n_compared;
  int          n_take;

  // Open-drain data line with pull-up; a released output shows no stale bit.
  wire logic sda_wire  = host_mosi & (o_mosi_oe ? o_mosi : 1'b1);
  wire logic miso_wire = o_miso_oe ? o_miso : ~miso_last;
  wire logic cs_pin    = i2c_sel ? strap1 : host_cs_n;
  wire logic miso_pin  = i2c_sel ? strap0 : miso_wire;

  initial i_sys_clk = 1'b0;
  always #5 i_sys_clk = ~i_sys_clk;

  always @(posedge i_sys_clk) begin
    if (o_miso_oe === 1'b1) miso_last <= o_miso;
    if (o_cmd_valid === 1'b1) cmd_q.push_back({o_cmd_first, o_cmd_data});
    if (o_rsp_take === 1'b1) n_take++;
  end

  dshcp_top u_dshcp_top (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
    .i_interface_select_strap(i2c_sel), .i_sclk(host_sclk),
    .i_chip_select_n(cs_pin), .i_mosi(sda_wire), .o_mosi(o_mosi),
    .o_mosi_oe(o_mosi_oe), .i_miso(miso_pin), .o_miso(o_miso),
    .o_miso_oe(o_miso_oe), .i_status(i_status), .i_rsp_data(i_rsp_data),
    .o_rsp_take(o_rsp_take), .o_cmd_data(o_cmd_data),
    .o_cmd_valid(o_cmd_valid), .o_cmd_first(o_cmd_first),
    .o_busy(o_busy), .o_i2c_mode(o_i2c_mode), .o_dev_addr(o_dev_addr));

  dshcp_host_model u_dshcp_host_model (
    .i_sys_clk(i_sys_clk), .i_miso_wire(miso_wire), .i_sda_wire(sda_wire),
    .o_sclk(host_sclk), .o_cs_n(host_cs_n), .o_mosi(host_mosi));

  // ***********************************************************************
  // Common tasks
  // ***********************************************************************
  task automatic check(input string name, input logic [39:0] seen,
                       input logic [39:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    if (failures == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic do_reset(input logic sel, input logic s1, input logic s0);
    i_sys_rst <= 1'b1;
    i2c_sel   <= sel;
    strap1    <= s1;
    strap0    <= s0;
    repeat (3) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
  endtask

  // ***********************************************************************
  // Scenarios
  // ***********************************************************************
  task automatic t_addr_straps;
    logic [1:0] a;
    for (int k = 0; k < 4; k++) begin
      a = k[1:0];
      do_reset(1'b1, a[1], a[0]);
      check("i2c_mode", 40'(o_i2c_mode), 40'h1);
      check("dev_addr", 40'(o_dev_addr), 40'({C_ADDR_UPPER, a}));
      // Straps moving after reset must not disturb the address.
      strap1 <= ~a[1];
      strap0 <= ~a[0];
      repeat (4) @(posedge i_sys_clk);
      check("addr_held", 40'(o_dev_addr), 40'({C_ADDR_UPPER, a}));
    end
  endtask

  task automatic t_spi(input logic mode3, input logic [39:0] tx);
    logic [39:0] rx;
    cmd_q.delete();
    u_dshcp_host_model.spi_frame(mode3, tx, rx);
    check("spi_rsp", rx, {i_status, i_rsp_data});
    check("spi_cmd_n", 40'(cmd_q.size()), 40'h5);
    check("spi_idle", 40'(o_busy), 40'h0);
    for (int i = 0; i < 5; i++) begin
      check("spi_cmd", 40'(cmd_q[i]), 40'({i == 0, tx[39-8*i -: 8]}));
    end
  endtask

  task automatic t_i2c_write(input logic [6:0] addr);
    logic [7:0] rx;
    logic       ack;
    cmd_q.delete();
    u_dshcp_host_model.i2c_start();
    u_dshcp_host_model.i2c_byte({addr, 1'b0}, 1'b1, rx, ack);
    check("wr_addr_ack", 40'(ack), 40'h0);
    u_dshcp_host_model.i2c_byte(8'hc3, 1'b1, rx, ack);
    check("wr_cmd_ack", 40'(ack), 40'h0);
    check("wr_busy", 40'(o_busy), 40'h1);
    u_dshcp_host_model.i2c_byte(8'h0f, 1'b1, rx, ack);
    check("wr_arg_ack", 40'(ack), 40'h0);
    u_dshcp_host_model.i2c_stop();
    check("wr_idle", 40'(o_busy), 40'h0);
    check("wr_n", 40'(cmd_q.size()), 40'h2);
    check("wr_cmd", 40'(cmd_q[0]), 40'({1'b1, 8'hc3}));
    check("wr_arg", 40'(cmd_q[1]), 40'({1'b0, 8'h0f}));
  endtask

  task automatic t_i2c_read(input logic [6:0] addr);
    logic [7:0]  rx;
    logic        ack;
    logic [39:0] exp;
    exp = {i_status, i_rsp_data};
    n_take = 0;
    u_dshcp_host_model.i2c_start();
    u_dshcp_host_model.i2c_byte({addr, C_RW_READ}, 1'b1, rx, ack);
    check("rd_addr_ack", 40'(ack), 40'h0);
    for (int i = 0; i < 5; i++) begin
      u_dshcp_host_model.i2c_byte(8'hff, i == 4, rx, ack);
      check("rd_byte", 40'(rx), 40'(exp[39-8*i -: 8]));
    end
    // After the unacknowledged byte the device must leave the line free.
    u_dshcp_host_model.i2c_bit(1'b1, ack);
    check("rd_released", 40'(ack), 40'h1);
    u_dshcp_host_model.i2c_stop();
    // Only the data byte after the four status bytes counts as taken.
    check("rd_take", 40'(n_take), 40'h1);
  endtask

  task automatic t_i2c_foreign(input logic [6:0] addr);
    logic [7:0] rx;
    logic       ack;
    cmd_q.delete();
    u_dshcp_host_model.i2c_start();
    u_dshcp_host_model.i2c_byte({addr ^ 7'h01, 1'b0}, 1'b1, rx, ack);
    check("foreign_ack", 40'(ack), 40'h1);
    u_dshcp_host_model.i2c_byte(8'h77, 1'b1, rx, ack);
    check("foreign_data", 40'(ack), 40'h1);
    u_dshcp_host_model.i2c_stop();
    check("foreign_n", 40'(cmd_q.size()), 40'h0);
  endtask

  // ***********************************************************************
  // Main sequence and watchdog
  // ***********************************************************************
  initial begin
    i_sys_rst  = 1'b1;
    i2c_sel    = 1'b0;
    strap1     = 1'b0;
    strap0     = 1'b0;
    miso_last  = 1'b0;
    i_status   = 32'h8123_4567;
    i_rsp_data = 8'h5a;
    t_addr_straps();
    do_reset(1'b0, 1'b0, 1'b0);
    check("spi_mode", 40'(o_i2c_mode), 40'h0);
    t_spi(1'b0, 40'ha5_3c_01_80_ff);
    t_spi(1'b1, 40'h11_22_33_44_55);
    do_reset(1'b1, 1'b1, 1'b0);
    t_i2c_write({C_ADDR_UPPER, 2'h2});
    t_i2c_read({C_ADDR_UPPER, 2'h2});
    t_i2c_foreign({C_ADDR_UPPER, 2'h2});
    report_and_stop();
  end

  // The whole run needs roughly 0.3 ms; twice that means a hang.
  initial begin
    #600000;
    failures++;
    report_and_stop();
  end
endmodule  // tb
